/* design/kbc_pkg.sv */
package kbc_pkg;
  // channel count and register widths
  localparam int CH_NUM = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int IRQ_W = 6;

  // register map, one byte address per register
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_RXCTL = 8'h04;
  localparam logic [7:0] OFS_BUF = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;

  // channel_status_control fields
  localparam int SC_ENABLE = 7;
  localparam int SC_CLK_MON = 6;
  localparam int SC_DAT_MON = 5;
  localparam int SC_FSEL = 4;
  localparam int SC_IRQ_EN = 3;
  localparam int SC_FULL = 2;
  localparam int SC_PERR = 1;
  localparam int SC_STOP = 0;

  // channel_receive_control fields
  localparam int RC_LOAD_EN = 7;
  localparam int RC_CLK_OUT = 6;
  localparam int RC_DAT_OUT = 5;
  localparam int RC_RSVD = 4;

  // reset values
  localparam logic SC_FSEL_RST = 1'h1;
  localparam logic RC_CLK_OUT_RST = 1'h1;
  localparam logic RC_DAT_OUT_RST = 1'h1;
  localparam logic RC_RSVD_VAL = 1'h1;
  localparam logic [7:0] BUF_RST = 8'h00;

  // receive counter positions
  localparam logic [CNT_W-1:0] CNT_IDLE = 4'h0;
  localparam logic [CNT_W-1:0] CNT_START = 4'h1;
  localparam logic [CNT_W-1:0] CNT_PARITY = 4'ha;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } kbc_bus_t;
endpackage

/* design/kbc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module kbc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* design/kbc_rdclr_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module kbc_rdclr_flag (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic set,
  input wire logic rd_hit,
  input wire logic wr_hit,
  input wire logic wr_bit,
  output logic flag_ff,
  output logic armed_ff
);
  // arm when software has seen the flag at one; any write disarms
  always_ff @(posedge core_clk) begin
    if (srst) begin
      armed_ff <= 1'h0;
    end else if (rd_hit && flag_ff) begin
      armed_ff <= 1'h1;
    end else if (wr_hit) begin
      armed_ff <= 1'h0;
    end
  end

  // set beats clear; only an armed write of zero clears
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag_ff <= 1'h0;
    end else if (set) begin
      flag_ff <= 1'h1;
    end else if (wr_hit && !wr_bit && armed_ff) begin
      flag_ff <= 1'h0;
    end
  end
endmodule
`default_nettype wire

/* design/kbc_top.sv */
// Notes on behaviour
// RULE_01: three independent channels, each with its own clock and data line.
// RULE_02: enable bit 7 resets 0; 0 releases lines, 1 puts them in bus drive.
// RULE_03: bit 6 reads current clock line level; writes ignored.
// RULE_04: bit 5 reads current data line level; writes ignored.
// RULE_05: bit 4 resets 1; 1 full means frame done, 0 means clock fall.
// RULE_06: software should clear load enable whenever it clears flag select.
// RULE_07: interrupt enable bit 3 resets 0; 0 blocks requests, 1 permits them.
// RULE_08: flag select 1 sets full bit 2 after a good frame loads the buffer.
// RULE_09: flag select 0 sets full on every clock line falling edge.
// RULE_10: full clears only by writing 0 after reading it as 1.
// RULE_11: parity error bit 1 sets on odd parity failure; read-then-write-0 clears.
// RULE_12: bit 0 holds received stop bit, meaningful only while full is 1.
// RULE_13: writing 1 to full or parity error does nothing; the code keeps the flag but the write disarms its clear.
// RULE_14: two causes per channel, frame done and clock edge, both via full.
// RULE_15: 4-bit counter advances per fall; zero on reset, load disable, after stop.
// RULE_16: load enable gates loading received bytes into the buffer.
// RULE_17: 8-bit read-only buffer holds received byte, valid while full is 1.
// RULE_18: frame is start, eight data lsb first, odd parity, stop; sampled on falls.
// RULE_19: channel request asserts while full and interrupt enable are both 1.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module kbc_top #(
  parameter int CH_NUM = kbc_pkg::CH_NUM
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire kbc_pkg::kbc_bus_t bus_req,
  output logic [kbc_pkg::DATA_W-1:0] rd_data_ff,
  input wire logic [CH_NUM-1:0] kb_clock_line_in,
  output logic [CH_NUM-1:0] kb_clock_line_out,
  output logic [CH_NUM-1:0] kb_clock_line_oe_n,
  input wire logic [CH_NUM-1:0] kb_data_line_in,
  output logic [CH_NUM-1:0] kb_data_line_out,
  output logic [CH_NUM-1:0] kb_data_line_oe_n,
  output logic [CH_NUM-1:0] ch_irq_ff,
  output logic irq_ff
);
  logic [CH_NUM-1:0] clk_s;
  logic [CH_NUM-1:0] dat_s;
  logic [CH_NUM-1:0] clk_prev_ff;
  logic [CH_NUM-1:0] fall;
  logic [CH_NUM-1:0] enable_ff;
  logic [CH_NUM-1:0] fsel_ff;
  logic [CH_NUM-1:0] ie_ff;
  logic [CH_NUM-1:0] load_en_ff;
  logic [CH_NUM-1:0] clk_out_ff;
  logic [CH_NUM-1:0] dat_out_ff;
  logic [CH_NUM-1:0] stop_ff;
  logic [CH_NUM-1:0] full;
  logic [CH_NUM-1:0] perr;
  logic [CH_NUM-1:0] full_armed;
  logic [CH_NUM-1:0] perr_armed;
  logic [CH_NUM-1:0] done;
  logic [CH_NUM-1:0] parity_ok;
  logic [CH_NUM-1:0] full_set;
  logic [CH_NUM-1:0] perr_set;
  logic [CH_NUM-1:0] sc_wr;
  logic [CH_NUM-1:0] sc_rd;
  logic [CH_NUM-1:0] rc_wr;
  logic [kbc_pkg::CNT_W-1:0] cnt_ff [CH_NUM];
  logic [8:0] shift_ff [CH_NUM];
  logic [7:0] buf_ff [CH_NUM];
  logic [7:0] sc_val [CH_NUM];
  logic [7:0] rc_val [CH_NUM];
  logic [kbc_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [kbc_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [kbc_pkg::IRQ_W-1:0] irq_ev;
  logic [kbc_pkg::DATA_W-1:0] nxt_rd_data;

  // line levels cross into the core clock domain
  kbc_sync #(.W(CH_NUM)) u_clk_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d(kb_clock_line_in),
    .q(clk_s)
  );

  kbc_sync #(.W(CH_NUM)) u_dat_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d(kb_data_line_in),
    .q(dat_s)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  genvar c;
  generate
    for (c = 0; c < CH_NUM; c++) begin : g_ch // [RULE_01]
      localparam logic [7:0] BASE = 8'(c * kbc_pkg::CH_STRIDE);

      // address decode for this channel
      assign sc_wr[c] = bus_req.wr && (bus_req.addr == BASE + kbc_pkg::OFS_STATUS);
      assign sc_rd[c] = bus_req.rd && (bus_req.addr == BASE + kbc_pkg::OFS_STATUS);
      assign rc_wr[c] = bus_req.wr && (bus_req.addr == BASE + kbc_pkg::OFS_RXCTL);

      // falling edge of the synchronised clock line
      always_ff @(posedge core_clk) begin
        if (srst) begin
          clk_prev_ff[c] <= 1'h1;
        end else begin
          clk_prev_ff[c] <= clk_s[c];
        end
      end
      assign fall[c] = clk_prev_ff[c] && !clk_s[c] && enable_ff[c];

      // control bits of the status register
      always_ff @(posedge core_clk) begin
        if (srst) begin
          enable_ff[c] <= 1'h0; // [RULE_02]
          fsel_ff[c] <= kbc_pkg::SC_FSEL_RST; // [RULE_05]
          ie_ff[c] <= 1'h0; // [RULE_07]
        end else if (sc_wr[c]) begin
          enable_ff[c] <= bus_req.wdata[kbc_pkg::SC_ENABLE];
          fsel_ff[c] <= bus_req.wdata[kbc_pkg::SC_FSEL];
          ie_ff[c] <= bus_req.wdata[kbc_pkg::SC_IRQ_EN];
        end
      end

      // receive control register
      always_ff @(posedge core_clk) begin
        if (srst) begin
          load_en_ff[c] <= 1'h0;
          clk_out_ff[c] <= kbc_pkg::RC_CLK_OUT_RST;
          dat_out_ff[c] <= kbc_pkg::RC_DAT_OUT_RST;
        end else if (rc_wr[c]) begin
          load_en_ff[c] <= bus_req.wdata[kbc_pkg::RC_LOAD_EN];
          clk_out_ff[c] <= bus_req.wdata[kbc_pkg::RC_CLK_OUT];
          dat_out_ff[c] <= bus_req.wdata[kbc_pkg::RC_DAT_OUT];
        end
      end

      // bit counter: start, data 0..7, parity, then stop returns to idle
      always_ff @(posedge core_clk) begin
        if (srst || !load_en_ff[c]) begin
          cnt_ff[c] <= kbc_pkg::CNT_IDLE; // [RULE_15] [RULE_16]
        end else if (fall[c]) begin
          if (cnt_ff[c] == kbc_pkg::CNT_PARITY) begin
            cnt_ff[c] <= kbc_pkg::CNT_IDLE; // [RULE_15]
          end else if (cnt_ff[c] != kbc_pkg::CNT_IDLE || !dat_s[c]) begin
            cnt_ff[c] <= cnt_ff[c] + kbc_pkg::CNT_START; // [RULE_18]
          end
        end
      end

      // data and parity shift in lsb first
      always_ff @(posedge core_clk) begin
        if (srst) begin
          shift_ff[c] <= '0;
        end else if (fall[c] && load_en_ff[c] && cnt_ff[c] != kbc_pkg::CNT_IDLE
                     && cnt_ff[c] != kbc_pkg::CNT_PARITY) begin
          shift_ff[c] <= {dat_s[c], shift_ff[c][8:1]}; // [RULE_18]
        end
      end

      // frame end on the stop bit fall; odd parity over data and parity
      assign done[c] = fall[c] && load_en_ff[c] && cnt_ff[c] == kbc_pkg::CNT_PARITY;
      assign parity_ok[c] = ^shift_ff[c];
      assign perr_set[c] = done[c] && !parity_ok[c]; // [RULE_11]

      // receive buffer and stop bit, cleared when the channel is disabled
      always_ff @(posedge core_clk) begin
        if (srst || !enable_ff[c]) begin
          buf_ff[c] <= kbc_pkg::BUF_RST;
          stop_ff[c] <= 1'h0;
        end else if (done[c] && parity_ok[c]) begin
          buf_ff[c] <= shift_ff[c][7:0]; // [RULE_17]
          stop_ff[c] <= dat_s[c]; // [RULE_12]
        end
      end

      // full source chosen by flag select
      assign full_set[c] = fsel_ff[c] ? (done[c] && parity_ok[c]) : fall[c]; // [RULE_05] [RULE_08] [RULE_09] [RULE_14]

      kbc_rdclr_flag u_full (
        .core_clk(core_clk),
        .srst(srst),
        .set(full_set[c]),
        .rd_hit(sc_rd[c]),
        .wr_hit(sc_wr[c]),
        .wr_bit(bus_req.wdata[kbc_pkg::SC_FULL]),
        .flag_ff(full[c]),
        .armed_ff(full_armed[c])
      ); // [RULE_10] [RULE_13]

      kbc_rdclr_flag u_perr (
        .core_clk(core_clk),
        .srst(srst),
        .set(perr_set[c]),
        .rd_hit(sc_rd[c]),
        .wr_hit(sc_wr[c]),
        .wr_bit(bus_req.wdata[kbc_pkg::SC_PERR]),
        .flag_ff(perr[c]),
        .armed_ff(perr_armed[c])
      ); // [RULE_11] [RULE_13]

      // open-drain lines: drive low only when enabled and the bit is low
      always_ff @(posedge core_clk) begin
        if (srst) begin
          kb_clock_line_out[c] <= 1'h0;
          kb_data_line_out[c] <= 1'h0;
          kb_clock_line_oe_n[c] <= 1'h1;
          kb_data_line_oe_n[c] <= 1'h1;
        end else begin
          kb_clock_line_out[c] <= 1'h0;
          kb_data_line_out[c] <= 1'h0;
          kb_clock_line_oe_n[c] <= !(enable_ff[c] && !clk_out_ff[c]); // [RULE_02]
          kb_data_line_oe_n[c] <= !(enable_ff[c] && !dat_out_ff[c]); // [RULE_02]
        end
      end

      // per-channel request
      always_ff @(posedge core_clk) begin
        if (srst) begin
          ch_irq_ff[c] <= 1'h0;
        end else begin
          ch_irq_ff[c] <= full[c] && ie_ff[c]; // [RULE_07] [RULE_19]
        end
      end

      // readable register images
      assign sc_val[c] = {enable_ff[c], clk_s[c], dat_s[c], fsel_ff[c], ie_ff[c],
                          full[c], perr[c], stop_ff[c]}; // [RULE_03] [RULE_04] [RULE_12]
      assign rc_val[c] = {load_en_ff[c], clk_out_ff[c], dat_out_ff[c],
                          kbc_pkg::RC_RSVD_VAL, cnt_ff[c]}; // [RULE_15]

      // stop bit fall; the buffer loads only on good parity, whatever the stop bit
      sequence stop_fall_s;
        fall[c] && load_en_ff[c] && cnt_ff[c] == kbc_pkg::CNT_PARITY;
      endsequence

      released_lines_a: assert property (!enable_ff[c] |=> kb_clock_line_oe_n[c] && kb_data_line_oe_n[c]) // [RULE_02]
        else $error("lines driven while controller disabled");
      clk_monitor_a: assert property (sc_rd[c] |=> rd_data_ff[kbc_pkg::SC_CLK_MON] == $past(clk_s[c])) // [RULE_03]
        else $error("clock monitor bit wrong");
      dat_monitor_a: assert property (sc_rd[c] |=> rd_data_ff[kbc_pkg::SC_DAT_MON] == $past(dat_s[c])) // [RULE_04]
        else $error("data monitor bit wrong");
      good_frame_full_a: assert property (stop_fall_s ##0 (fsel_ff[c] && parity_ok[c])
                                           |=> full[c] && buf_ff[c] == $past(shift_ff[c][7:0])) // [RULE_08]
        else $error("good frame did not load buffer and set full");
      edge_full_a: assert property (fall[c] && !fsel_ff[c] |=> full[c]) // [RULE_09]
        else $error("clock fall did not set full");
      unarmed_keep_a: assert property (full[c] && sc_wr[c] && !full_armed[c] |=> full[c]) // [RULE_10]
        else $error("full cleared without prior read");
      write_one_a: assert property (perr[c] && sc_wr[c] && bus_req.wdata[kbc_pkg::SC_PERR] |=> perr[c]) // [RULE_13]
        else $error("writing one cleared parity error");
      parity_err_a: assert property (stop_fall_s ##0 !parity_ok[c] |=> perr[c] && $stable(buf_ff[c])) // [RULE_11]
        else $error("parity failure not flagged");
      count_idle_a: assert property (stop_fall_s or !load_en_ff[c] |=> cnt_ff[c] == kbc_pkg::CNT_IDLE) // [RULE_15]
        else $error("receive counter not idle");
      ch_request_a: assert property (full[c] && ie_ff[c] |=> ch_irq_ff[c] ##0 $past(full[c], 1)) // [RULE_19]
        else $error("channel request not raised");
    end
  endgenerate

  // interrupt events: request rising per channel, parity error per channel
  assign irq_ev = {perr_set, full & ie_ff & ~ch_irq_ff};

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_ff <= '0;
    end else if (bus_req.wr && bus_req.addr == kbc_pkg::OFS_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~bus_req.wdata[kbc_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_ev;
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_mask_ff <= '0;
    end else if (bus_req.wr && bus_req.addr == kbc_pkg::OFS_IRQ_MASK) begin
      irq_mask_ff <= bus_req.wdata[kbc_pkg::IRQ_W-1:0];
    end
  end

  // single level interrupt
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_ff <= 1'h0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rd_data = '0;
    for (int i = 0; i < CH_NUM; i++) begin
      if (bus_req.addr == 8'(i * kbc_pkg::CH_STRIDE) + kbc_pkg::OFS_STATUS) begin
        nxt_rd_data = sc_val[i];
      end
      if (bus_req.addr == 8'(i * kbc_pkg::CH_STRIDE) + kbc_pkg::OFS_RXCTL) begin
        nxt_rd_data = rc_val[i];
      end
      if (bus_req.addr == 8'(i * kbc_pkg::CH_STRIDE) + kbc_pkg::OFS_BUF) begin
        nxt_rd_data = buf_ff[i];
      end
    end
    if (bus_req.addr == kbc_pkg::OFS_IRQ_STAT) begin
      nxt_rd_data = {2'h0, irq_stat_ff};
    end
    if (bus_req.addr == kbc_pkg::OFS_IRQ_MASK) begin
      nxt_rd_data = {2'h0, irq_mask_ff};
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data_ff <= '0;
    end else if (bus_req.rd) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= '0;
    end
  end

  irq_level_a: assert property (|(irq_stat_ff & irq_mask_ff) |=> irq_ff)
    else $error("interrupt output not raised");
endmodule
`default_nettype wire

/* dv/kbc_kbd_model.sv */
`timescale 1ns/1ps
`default_nettype none
module kbc_kbd_model (
  output logic [2:0] clk_low,
  output logic [2:0] dat_low
);
  // lines released between frames, clock stands still high
  initial begin
    clk_low = 3'h0;
    dat_low = 3'h0;
  end
  // one frame on one channel, 320 ns link clock
  task automatic send(input int ch, input logic [7:0] b, input logic bad_par, input logic stop);
    logic [10:0] bits;
    bits = {stop, (~^b) ^ bad_par, b, 1'h0};
    for (int i = 0; i < 11; i++) begin
      dat_low[ch] = ~bits[i]; // data moves while clock high
      #80;
      clk_low[ch] = 1'h1; // receiver samples on this fall
      #160;
      clk_low[ch] = 1'h0;
      #80;
    end
    dat_low[ch] = 1'h0;
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb_top;
  typedef struct packed {
    logic [1:0] ch;
    logic [7:0] b;
    logic bad;
    logic stop;
  } kbc_row_t;
  logic core_clk;
  logic srst;
  kbc_pkg::kbc_bus_t bus_req;
  logic [7:0] rd_data_ff;
  logic [2:0] clk_line, clk_out, clk_oe_n, dat_line, dat_out, dat_oe_n, m_clk, m_dat, ch_irq_ff;
  logic irq_ff;
  int errors = 0;
  int checks = 0;
  logic [7:0] d, base, exp_st;
  logic [7:0] buf_exp [3];
  kbc_row_t rows [6];
  // pulled-up open-drain lines, low if anyone pulls
  assign clk_line = ~((~clk_oe_n & ~clk_out) | m_clk);
  assign dat_line = ~((~dat_oe_n & ~dat_out) | m_dat);
  kbc_top i_kbc_top (.core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
    .kb_clock_line_in(clk_line), .kb_clock_line_out(clk_out), .kb_clock_line_oe_n(clk_oe_n),
    .kb_data_line_in(dat_line), .kb_data_line_out(dat_out), .kb_data_line_oe_n(dat_oe_n),
    .ch_irq_ff(ch_irq_ff), .irq_ff(irq_ff));
  kbc_kbd_model i_kbc_kbd_model (.clk_low(m_clk), .dat_low(m_dat));
  // 25 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  // bus write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_req.wr <= 1'h1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge core_clk);
    bus_req.wr <= 1'h0;
  endtask
  // bus read, data sampled in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req.rd <= 1'h1;
    bus_req.addr <= a;
    @(posedge core_clk);
    bus_req.rd <= 1'h0;
    #1;
    d = rd_data_ff;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  initial begin
    bus_req = '0;
    srst = 1'h1;
    rows = '{'{2'h0, 8'ha5, 1'h0, 1'h1}, '{2'h1, 8'h00, 1'h0, 1'h1}, '{2'h2, 8'hff, 1'h0, 1'h0},
             '{2'h0, 8'h3c, 1'h1, 1'h1}, '{2'h1, 8'h81, 1'h0, 1'h1}, '{2'h2, 8'h7e, 1'h1, 1'h1}};
    buf_exp = '{8'h00, 8'h00, 8'h00};
    repeat (6) @(posedge core_clk);
    srst <= 1'h0;
    repeat (4) @(posedge core_clk);
    // reset values and unmapped address
    rd(8'h00); `CHK("status rst", 8'h70, d)
    rd(8'h04); `CHK("rxctl rst", 8'h70, d)
    rd(8'h08); `CHK("buf rst", 8'h00, d)
    rd(8'h3c); `CHK("unmapped", 8'h00, d)
    for (int c = 0; c < 3; c++) begin
      wr(8'(c * 16), 8'h90);
      wr(8'(c * 16 + 4), 8'he0);
    end
    // ordinary frames: good, bad parity, stop 0, all channels
    foreach (rows[i]) begin
      base = {2'h0, rows[i].ch, 4'h0};
      i_kbc_kbd_model.send(rows[i].ch, rows[i].b, rows[i].bad, rows[i].stop);
      repeat (8) @(posedge core_clk);
      if (!rows[i].bad) buf_exp[rows[i].ch] = rows[i].b;
      exp_st = rows[i].bad ? 8'hf2 : (8'hf4 | rows[i].stop);
      rd(base); `CHK("status", exp_st, d & (rows[i].bad ? 8'hfe : 8'hff))
      rd(base + 8'h08); `CHK("buffer", buf_exp[rows[i].ch], d)
      rd(base + 8'h04); `CHK("counter", 8'hf0, d)
      rd(8'h30); `CHK("irq stat", rows[i].bad ? 8'h08 << rows[i].ch : 8'h00, d)
      wr(8'h30, 8'h3f);
      rd(base);
      wr(base, 8'h96);
      wr(base, 8'h90);
      rd(base); `CHK("no clear", exp_st, d & (rows[i].bad ? 8'hfe : 8'hff))
      wr(base, 8'h90);
      rd(base); `CHK("cleared", 8'hf0, d & 8'hfe)
    end
    // interrupt raise, mask, clear on channel 1
    wr(8'h10, 8'h98);
    wr(8'h34, 8'h02);
    i_kbc_kbd_model.send(1, 8'h5a, 1'h0, 1'h1);
    repeat (8) @(posedge core_clk);
    `CHK("ch irq", 1'h1, ch_irq_ff[1])
    `CHK("irq", 1'h1, irq_ff)
    rd(8'h30); `CHK("irq stat", 8'h02, d)
    wr(8'h34, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK("irq masked", 1'h0, irq_ff)
    wr(8'h34, 8'h02);
    wr(8'h30, 8'h02);
    repeat (2) @(posedge core_clk);
    `CHK("irq w1c", 1'h0, irq_ff)
    rd(8'h10);
    wr(8'h10, 8'h98);
    repeat (2) @(posedge core_clk);
    `CHK("ch irq clr", 1'h0, ch_irq_ff[1])
    // fall-edge flag mode with loading off on channel 2
    wr(8'h24, 8'h60);
    wr(8'h20, 8'h80);
    i_kbc_kbd_model.send(2, 8'h33, 1'h0, 1'h1);
    repeat (8) @(posedge core_clk);
    rd(8'h20); `CHK("fall flag", 8'he4, d & 8'hfe)
    rd(8'h24); `CHK("counter held", 8'h70, d)
    wr(8'h20, 8'h90);
    i_kbc_kbd_model.send(2, 8'h11, 1'h0, 1'h1);
    repeat (8) @(posedge core_clk);
    rd(8'h20); `CHK("no load", 8'hf0, d & 8'hfe)
    rd(8'h28); `CHK("buf kept", 8'hff, d)
    // device pulls its own lines low on channel 0
    wr(8'h04, 8'h80);
    repeat (4) @(posedge core_clk);
    `CHK("clk oe_n", 1'h0, clk_oe_n[0])
    `CHK("dat oe_n", 1'h0, dat_oe_n[0])
    `CHK("line out", 6'h00, {clk_out, dat_out})
    rd(8'h00); `CHK("monitors low", 8'h90, d & 8'hfe)
    wr(8'h00, 8'h00);
    repeat (4) @(posedge core_clk);
    `CHK("released", 3'h7, {clk_oe_n[0], dat_oe_n[0], clk_oe_n[1]})
    rd(8'h00); `CHK("monitor ro", 8'h60, d)
    rd(8'h08); `CHK("buf off", 8'h00, d)
    wrap_up();
  end
endmodule
`default_nettype wire
